// *** src/rfp_consts.vh ***
`ifndef RFP_CONSTS_VH
`define RFP_CONSTS_VH

// Result bank geometry
`define RFP_NUM_REGS 32
`define RFP_RES_W 16
`define RFP_BANK_W 512
`define RFP_REG_AW 5
`define RFP_IDX_W 4

// Forwarding and decoder geometry
`define RFP_SLOTS 8
`define RFP_NUM_SEL 16
`define RFP_NUM_LUT 4
`define RFP_LUT_AW 16

// Register byte offsets and block base address bits
`define RFP_OFS_CTRL 9'h000
`define RFP_OFS_STATUS 9'h004
`define RFP_OFS_LUT_PTR 9'h008
`define RFP_OFS_LUT_DATA 9'h00C
`define RFP_OFS_DEC_BASE 3'b001
`define RFP_OFS_PORT_BASE 1'b1

// Field positions
`define RFP_CTRL_RUN 0
`define RFP_CTRL_CLEAR 1
`define RFP_PCFG_EN 0
`define RFP_PCFG_SRC 1
`define RFP_PCFG_BSEL_LO 4
`define RFP_SEL_REG_LO 0
`define RFP_SEL_IDX_LO 8
`define RFP_SLOT_EN 16

// Reset values
`define RFP_RST_RUN 1'b0
`define RFP_RST_PTR 18'h0_0000
`define RFP_RST_CNT 16'h0000
`define RFP_RST_PCFG 4'h0
`define RFP_RST_SEL 9'h000
`define RFP_RST_SLOT 10'h000

// Clock edges from result write to feedback output
`define RFP_FB_LAT 2

`endif

// *** src/rfp_result_bank.v ***
`timescale 1ns/1ps
`include "rfp_consts.vh"

module rfp_result_bank (
    input wire clk_in,
    input wire srst_in,
    input wire clr_in,
    input wire wr_in,
    input wire [`RFP_REG_AW-1:0] addr_in,
    input wire [`RFP_RES_W-1:0] data_in,
    input wire [`RFP_RES_W-1:0] mask_in,
    output wire [`RFP_BANK_W-1:0] bank_out
);

reg [`RFP_RES_W-1:0] mem [0:`RFP_NUM_REGS-1];
integer i;

////////////////////////////////////////////////////////////////////////////////
// thirty-two result words
always @(posedge clk_in) begin
    if (srst_in || clr_in) begin
        for (i = 0; i < `RFP_NUM_REGS; i = i + 1) begin
            mem[i] <= {`RFP_RES_W{1'b0}};
        end
    end
    if (!srst_in && wr_in) begin
        mem[addr_in] <= ((clr_in ? {`RFP_RES_W{1'b0}} : mem[addr_in]) & ~mask_in) | (data_in & mask_in);
    end
end

genvar g;
generate
    for (g = 0; g < `RFP_NUM_REGS; g = g + 1) begin : flat
        assign bank_out[g*`RFP_RES_W +: `RFP_RES_W] = mem[g];
    end
endgenerate

endmodule

// *** src/rfp_lut_tables.v ***
`timescale 1ns/1ps
`include "rfp_consts.vh"

module rfp_lut_tables (
    input wire clk_in,
    input wire srst_in,
    input wire we_in,
    input wire [1:0] wtbl_in,
    input wire [`RFP_LUT_AW-1:0] waddr_in,
    input wire [7:0] wdata_in,
    input wire re_in,
    input wire [`RFP_LUT_AW-1:0] raddr_in,
    output wire [8*`RFP_NUM_LUT-1:0] q_out
);

genvar t;
generate
    for (t = 0; t < `RFP_NUM_LUT; t = t + 1) begin : tbl
        reg [7:0] mem [0:(1<<`RFP_LUT_AW)-1];
        reg [7:0] q;
        always @(posedge clk_in) begin
            if (we_in && wtbl_in == t) begin
                mem[waddr_in] <= wdata_in;
            end
        end
        always @(posedge clk_in) begin
            if (srst_in) begin
                q <= 8'h00;
            end else if (re_in) begin
                q <= mem[raddr_in];
            end
        end
        assign q_out[t*8 +: 8] = q;
    end
endgenerate

endmodule

// *** src/rfp_feedback_top.v ***
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rfp_consts.vh"

// Functional notes
// - Bank of 32 result words, 16 results each, narrower writers use fewer.
// - A result write changes only masked positions, others unchanged.
// - Each write lands at the address carried with it.
// - Software clears the whole bank at once; contents never readable.
// - Each output port has eight slots, register number plus index.
// - Each slot fills one bit pair of the forwarded message.
// - Slot selections are private to each port.
// - A write to a register a port's slots use sends forwarding.
// - Decoder reads any bank bit, outputs one byte per port.
// - Sixteen selectors, register plus bit, form a 16-bit table address.
// - Address indexes four tables, each returning one byte.
// - Per port selector picks one of the four table bytes.
// - Any result write re-evaluates tables and sends byte with trigger.
// - Decoder latency fixed, independent of address and contents.
// - Port enable bit; cleared means no messages on that port.
// - Per port source select: forwarding or decoder.
// - Feedback only while trigger generation runs.
module rfp_feedback_top #(
    parameter NUM_OUT = 4
) (
    input wire clk_in,
    input wire srst_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    input wire res_wr_in,
    input wire [`RFP_REG_AW-1:0] res_addr_in,
    input wire [`RFP_RES_W-1:0] res_data_in,
    input wire [`RFP_RES_W-1:0] res_mask_in,
    output reg [NUM_OUT-1:0] fb_valid_out,
    output reg [NUM_OUT-1:0] fb_dec_out,
    output reg [NUM_OUT*16-1:0] fb_data_out
);

localparam [2:0] NUM_OUT3 = NUM_OUT;

function sel_bit;
    input [`RFP_BANK_W-1:0] bank;
    input [`RFP_REG_AW-1:0] r;
    input [`RFP_IDX_W-1:0] i;
    begin
        sel_bit = bank[{r, i}];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: writes zero-wait, reads one wait state

wire acc = hsel_in & htrans_in[1] & hready_in;
reg ap_wr;
reg ap_rd;
reg [8:0] ap_addr;
reg [31:0] rd_mux;

always @(posedge clk_in) begin
    if (srst_in) begin
        ap_wr <= 1'b0;
        ap_rd <= 1'b0;
        ap_addr <= 9'h000;
        hreadyout_out <= 1'b1;
        hrdata_out <= 32'h0000_0000;
        hresp_out <= 1'b0;
    end else begin
        ap_wr <= acc & hwrite_in;
        ap_rd <= acc & ~hwrite_in;
        if (acc) begin
            ap_addr <= haddr_in[8:0];
        end
        if (acc && !hwrite_in) begin
            hreadyout_out <= 1'b0;
        end else if (ap_rd) begin
            hreadyout_out <= 1'b1;
            hrdata_out <= rd_mux;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register decode

wire [1:0] pidx = ap_addr[7:6];
wire [3:0] widx = ap_addr[5:2];
wire [3:0] wm1 = widx - 4'h1;
wire port_hit = (ap_addr[8] == `RFP_OFS_PORT_BASE) && ({1'b0, pidx} < NUM_OUT3);
wire slot_hit = port_hit && (widx != 4'h0) && (widx <= 4'h8);
wire dec_hit = (ap_addr[8:6] == `RFP_OFS_DEC_BASE);
wire wr_ctrl = ap_wr && (ap_addr == `RFP_OFS_CTRL);
wire wr_ptr = ap_wr && (ap_addr == `RFP_OFS_LUT_PTR);
wire wr_lut = ap_wr && (ap_addr == `RFP_OFS_LUT_DATA);
wire bank_clr = wr_ctrl && hwdata_in[`RFP_CTRL_CLEAR];

reg run;
reg [15:0] wr_cnt;
reg [17:0] lut_ptr;
reg [8:0] dsel [0:`RFP_NUM_SEL-1];
reg [3:0] pcfg [0:NUM_OUT-1];
reg [9:0] slot [0:NUM_OUT*`RFP_SLOTS-1];
integer n;

always @(posedge clk_in) begin
    if (srst_in) begin
        run <= `RFP_RST_RUN;
        wr_cnt <= `RFP_RST_CNT;
        lut_ptr <= `RFP_RST_PTR;
        for (n = 0; n < `RFP_NUM_SEL; n = n + 1) begin
            dsel[n] <= `RFP_RST_SEL;
        end
        for (n = 0; n < NUM_OUT; n = n + 1) begin
            pcfg[n] <= `RFP_RST_PCFG;
        end
        for (n = 0; n < NUM_OUT*`RFP_SLOTS; n = n + 1) begin
            slot[n] <= `RFP_RST_SLOT;
        end
    end else begin
        if (wr_ctrl) begin
            run <= hwdata_in[`RFP_CTRL_RUN];
        end
        if (res_wr_in) begin
            wr_cnt <= wr_cnt + 16'h0001;
        end
        if (wr_ptr) begin
            lut_ptr <= hwdata_in[17:0];
        end else if (wr_lut) begin
            lut_ptr <= {lut_ptr[17:16], lut_ptr[15:0] + 16'h0001};
        end
        if (ap_wr && dec_hit) begin
            dsel[widx] <= {hwdata_in[`RFP_SEL_IDX_LO +: 4], hwdata_in[`RFP_SEL_REG_LO +: 5]};
        end
        if (ap_wr && port_hit && widx == 4'h0) begin
            pcfg[pidx] <= {hwdata_in[`RFP_PCFG_BSEL_LO +: 2], hwdata_in[`RFP_PCFG_SRC], hwdata_in[`RFP_PCFG_EN]};
        end
        if (ap_wr && slot_hit) begin
            slot[{pidx, wm1[2:0]}] <= {hwdata_in[`RFP_SLOT_EN], hwdata_in[`RFP_SEL_IDX_LO +: 4],
                hwdata_in[`RFP_SEL_REG_LO +: 5]};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read mux; bank contents and table bytes read as zero

reg [8:0] rd_sel;
reg [9:0] rd_slot;

always @* begin
    rd_mux = 32'h0000_0000;
    rd_sel = dsel[widx];
    rd_slot = slot[{pidx, wm1[2:0]}];
    if (ap_addr == `RFP_OFS_CTRL) begin
        rd_mux = {31'h0000_0000, run};
    end else if (ap_addr == `RFP_OFS_STATUS) begin
        rd_mux = {16'h0000, wr_cnt};
    end else if (ap_addr == `RFP_OFS_LUT_PTR) begin
        rd_mux = {14'h0000, lut_ptr};
    end else if (dec_hit) begin
        rd_mux = {20'h0_0000, rd_sel[8:5], 3'b000, rd_sel[4:0]};
    end else if (port_hit && widx == 4'h0) begin
        rd_mux = {26'h000_0000, pcfg[pidx][3:2], 2'b00, pcfg[pidx][1:0]};
    end else if (slot_hit) begin
        rd_mux = {15'h0000, rd_slot[9], 4'h0, rd_slot[8:5], 3'b000, rd_slot[4:0]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Result bank and lookup tables

wire [`RFP_BANK_W-1:0] bank;
wire [8*`RFP_NUM_LUT-1:0] lut_q;
reg [`RFP_LUT_AW-1:0] dec_addr;
reg s1_vld;
reg [`RFP_REG_AW-1:0] s1_addr;

rfp_result_bank u_bank (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clr_in(bank_clr),
    .wr_in(res_wr_in),
    .addr_in(res_addr_in),
    .data_in(res_data_in),
    .mask_in(res_mask_in),
    .bank_out(bank)
);

rfp_lut_tables u_lut (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .we_in(wr_lut),
    .wtbl_in(lut_ptr[17:16]),
    .waddr_in(lut_ptr[15:0]),
    .wdata_in(hwdata_in[7:0]),
    .re_in(s1_vld),
    .raddr_in(dec_addr),
    .q_out(lut_q)
);

////////////////////////////////////////////////////////////////////////////////
// Stage 1: bank already holds the triggering write

reg [NUM_OUT*16-1:0] fwd_c;
reg [NUM_OUT-1:0] hit_c;
reg [9:0] se;
reg [3:0] nx;
integer p;
integer s;
integer k;

always @* begin
    fwd_c = {NUM_OUT*16{1'b0}};
    hit_c = {NUM_OUT{1'b0}};
    se = 10'h000;
    nx = 4'h0;
    dec_addr = {`RFP_LUT_AW{1'b0}};
    for (k = 0; k < `RFP_NUM_SEL; k = k + 1) begin
        dec_addr[k] = sel_bit(bank, dsel[k][4:0], dsel[k][8:5]);
    end
    for (p = 0; p < NUM_OUT; p = p + 1) begin
        for (s = 0; s < `RFP_SLOTS; s = s + 1) begin
            se = slot[p*`RFP_SLOTS + s];
            nx = se[8:5] + 4'h1;
            if (se[9]) begin
                fwd_c[p*16 + 2*s] = sel_bit(bank, se[4:0], se[8:5]);
                fwd_c[p*16 + 2*s + 1] = sel_bit(bank, se[4:0], nx);
                if (se[4:0] == s1_addr) begin
                    hit_c[p] = 1'b1;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stage 2 and output

reg s2_vld;
reg [NUM_OUT-1:0] s2_hit;
reg [NUM_OUT*16-1:0] s2_fwd;
reg [NUM_OUT-1:0] send_c;

always @* begin
    send_c = {NUM_OUT{1'b0}};
    for (p = 0; p < NUM_OUT; p = p + 1) begin
        send_c[p] = s2_vld & run & pcfg[p][0] & (pcfg[p][1] | s2_hit[p]);
    end
end

always @(posedge clk_in) begin
    if (srst_in) begin
        s1_vld <= 1'b0;
        s1_addr <= {`RFP_REG_AW{1'b0}};
        s2_vld <= 1'b0;
        s2_hit <= {NUM_OUT{1'b0}};
        s2_fwd <= {NUM_OUT*16{1'b0}};
        fb_valid_out <= {NUM_OUT{1'b0}};
        fb_dec_out <= {NUM_OUT{1'b0}};
        fb_data_out <= {NUM_OUT*16{1'b0}};
    end else begin
        s1_vld <= res_wr_in & run;
        s1_addr <= res_addr_in;
        s2_vld <= s1_vld & run;
        s2_hit <= hit_c;
        s2_fwd <= fwd_c;
        fb_valid_out <= send_c;
        for (p = 0; p < NUM_OUT; p = p + 1) begin
            if (send_c[p]) begin
                fb_dec_out[p] <= pcfg[p][1];
                if (pcfg[p][1]) begin
                    fb_data_out[p*16 +: 16] <= {8'h00, lut_q[pcfg[p][3:2]*8 +: 8]};
                end else begin
                    fb_data_out[p*16 +: 16] <= s2_fwd[p*16 +: 16];
                end
            end
        end
    end
end

endmodule

// *** test/rfp_feedback_checker.sv ***
`timescale 1ns/1ps
module rfp_feedback_checker #(
    parameter NUM_OUT = 4
) (
    input wire clk_in,
    input wire srst_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    input wire [31:0] hrdata_out,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire res_wr_in,
    input wire [4:0] res_addr_in,
    input wire [15:0] res_data_in,
    input wire [15:0] res_mask_in,
    input wire [NUM_OUT-1:0] fb_valid_out,
    input wire [NUM_OUT-1:0] fb_dec_out,
    input wire [NUM_OUT*16-1:0] fb_data_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////
    sequence rd_req;
        hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    endsequence
    sequence wr_req;
        hsel_in && htrans_in[1] && hready_in && hwrite_in;
    endsequence
    sequence rd_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    rd_wait_a:
        assert property (rd_req |=> rd_wait) else $error("read wait state wrong");
    wr_nowait_a:
        assert property (wr_req |=> hreadyout_out) else $error("write stalled");
    bus_okay_a:
        assert property (hresp_out == 1'b0) else $error("response not okay");
    rd_hold_a:
        assert property (hreadyout_out && $past(hreadyout_out) |-> $stable(hrdata_out)) else $error("read data moved");
    fb_lat_a:
        assert property ((|fb_valid_out) |-> $past(res_wr_in, 3)) else $error("message without write");
    dec_byte_a:
        assert property (fb_valid_out[1] && fb_dec_out[1] |-> fb_data_out[31:24] == 8'h00) else $error("wide decoder byte");
    data_hold_a:
        assert property (!fb_valid_out[0] |-> $stable(fb_data_out[15:0])) else $error("payload moved");
    src_hold_a:
        assert property (!fb_valid_out[0] |-> $stable(fb_dec_out[0])) else $error("source flag moved");
endmodule

bind rfp_feedback_top rfp_feedback_checker #(.NUM_OUT(NUM_OUT)) i_chk (.clk_in(clk_in), .srst_in(srst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .res_wr_in(res_wr_in), .res_addr_in(res_addr_in), .res_data_in(res_data_in),
    .res_mask_in(res_mask_in), .fb_valid_out(fb_valid_out), .fb_dec_out(fb_dec_out), .fb_data_out(fb_data_out));

// *** test/rfp_meas_model.sv ***
`timescale 1ns/1ps
module rfp_meas_model (
    input wire clk_in,
    output logic res_wr_out,
    output logic [4:0] res_addr_out,
    output logic [15:0] res_data_out,
    output logic [15:0] res_mask_out
);
    initial begin
        res_wr_out = 1'b0;
        res_addr_out = 5'h00;
        res_data_out = 16'h0000;
        res_mask_out = 16'h0000;
    end
    task automatic send(input logic [4:0] a, input logic [15:0] d, input logic [15:0] m);
        @(posedge clk_in);
        res_addr_out <= a;
        res_data_out <= d;
        res_mask_out <= m;
        res_wr_out <= 1'b1;
        @(posedge clk_in);
        res_wr_out <= 1'b0;
        // Idle lines show inverse
        res_addr_out <= ~a;
        res_data_out <= ~d;
        res_mask_out <= ~m;
    endtask
endmodule

// *** test/readout_feedback_pipeline_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module readout_feedback_pipeline_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire [31:0] hrdata;
    wire hready;
    wire res_wr;
    wire [4:0] res_addr;
    wire [15:0] res_data;
    wire [15:0] res_mask;
    wire [3:0] fb_valid;
    wire [3:0] fb_dec;
    wire [63:0] fb_data;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'ha684_e7ba;
    logic [15:0] bank [32];
    logic [31:0] q;
    always #10 clk_in = ~clk_in;
    rfp_feedback_top #(.NUM_OUT(4)) i_dut (.clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(), .res_wr_in(res_wr), .res_addr_in(res_addr),
        .res_data_in(res_data), .res_mask_in(res_mask), .fb_valid_out(fb_valid), .fb_dec_out(fb_dec),
        .fb_data_out(fb_data));
    rfp_meas_model i_meas (.clk_in(clk_in), .res_wr_out(res_wr), .res_addr_out(res_addr),
        .res_data_out(res_data), .res_mask_out(res_mask));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    function automatic logic [15:0] fwd();
        logic [15:0] f;
        for (int s = 0; s < 8; s++) begin
            f[2*s] = bank[s < 4 ? 2 : 3][(3*s) % 16];
            f[2*s+1] = bank[s < 4 ? 2 : 3][(3*s+1) % 16];
        end
        return f;
    endfunction
    function automatic logic [7:0] lut(input logic [15:0] a);
        return a[7:0] * 8'h25 + 8'h05;
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] a;
        logic [15:0] d;
        logic [15:0] m;
        foreach (bank[j]) bank[j] = 16'h0000;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, q);
        `CHK("status", 32'h0000_0000, q)
        bus(1'b0, 32'h0000_0010, 32'h0000_0000, q);
        `CHK("unmapped", 32'h0000_0000, q)
        bus(1'b1, 32'h0000_0100, 32'h0000_0001, q);
        bus(1'b0, 32'h0000_0100, 32'h0000_0000, q);
        `CHK("port cfg", 32'h0000_0001, q)
        // Slot 5 wraps from bit 15 to bit 0
        for (int s = 0; s < 8; s++) bus(1'b1, 32'h0000_0104 + 4 * s, 32'h0001_0000 | ((3 * s) << 8) | (s < 4 ? 2 : 3), q);
        for (int k = 0; k < 16; k++) bus(1'b1, 32'h0000_0040 + 4 * k, (k << 8) | 1, q);
        bus(1'b1, 32'h0000_0140, 32'h0000_0023, q);
        bus(1'b1, 32'h0000_0180, 32'h0000_0002, q);
        bus(1'b1, 32'h0000_01C0, 32'h0000_0001, q);
        bus(1'b1, 32'h0000_0008, 32'h0002_0000, q);
        for (int k = 0; k < 8; k++) bus(1'b1, 32'h0000_000C, {24'h00_0000, lut(k)}, q);
        bus(1'b0, 32'h0000_000C, 32'h0000_0000, q);
        `CHK("table read", 32'h0000_0000, q)
        $display("test map done");
        i_meas.send(5'h04, 16'hffff, 16'hffff);
        repeat (3) @(posedge clk_in);
        #1;
        `CHK("run off", 4'h0, fb_valid)
        bus(1'b1, 32'h0000_0000, 32'h0000_0001, q);
        $display("test gate done");
        for (int i = 0; i < 40; i++) begin
            a = $random(seed);
            d = $random(seed);
            m = $random(seed);
            if (i % 5 == 0) a = 5'h02 + i[0];
            if (a == 1) begin
                m = 16'hffff;
                d = d & 16'h0007;
            end
            if (i == 20) begin
                bus(1'b1, 32'h0000_0000, 32'h0000_0003, q);
                foreach (bank[j]) bank[j] = 16'h0000;
            end
            i_meas.send(a, d, m);
            bank[a] = (bank[a] & ~m) | (d & m);
            repeat (2) @(posedge clk_in);
            #1;
            `CHK("valid", {3'b001, a == 2 || a == 3}, fb_valid)
            if (a == 2 || a == 3) `CHK("fwd", fwd(), fb_data[15:0])
            `CHK("dec", {8'h00, lut(bank[1])}, fb_data[31:16])
            `CHK("src", 2'b10, fb_dec[1:0])
        end
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, q);
        `CHK("count", 32'h0000_0029, q)
        $display("test random done");
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk_in);
        error_cnt++;
        complete_run();
    end
endmodule
